//--- logic/dpsm_device.sv
// converter control end: mode pins, serial registers, data capture
`timescale 1ns/1ps
`include "dpsm_cfg.svh"

module dpsm_device
    import dpsm_pkg::*;
#(
    parameter int DATA_W = `DPSM_DATA_W
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // pin link
    dpsm_if.device lnk,
    // converter side
    output logic [DATA_W-1:0] o_true_code,
    output logic [DATA_W-1:0] o_comp_code,
    output logic o_powered_down,
    output logic o_clk_diff,
    output logic o_twos_fmt,
    output logic o_serial_mode
);
    logic [3:0] pin_s;
    logic mode_s;
    logic pdcs_s;
    logic fmt_s;
    logic sclk_s;

    dpsm_sync #(
        .W(4)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_d({lnk.mode_sel, lnk.powerdown_or_select,
              lnk.fmt_line, lnk.clk_type_or_serial_clock}),
        .o_q(pin_s)
    );

    assign mode_s = pin_s[3];
    assign pdcs_s = pin_s[2];
    assign fmt_s = pin_s[1];
    assign sclk_s = pin_s[0];

    // serial clock edges
    logic sclk_d_r;
    logic sclk_rise;
    logic sclk_fall;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sclk_d_r <= 1'b0;
        end else if (i_ce) begin
            sclk_d_r <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;

    // serial port state
    dpsm_dev_st_e st_r;
    dpsm_dev_st_e st_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [`DPSM_BYTE_W-1:0] sh_r;
    logic [`DPSM_BYTE_W-1:0] sh_nxt;
    logic rd_r;
    logic rd_nxt;
    logic [`DPSM_ADDR_W-1:0] adr_r;
    logic [`DPSM_ADDR_W-1:0] adr_nxt;
    logic fall_r;
    logic fall_nxt;
    logic [`DPSM_BYTE_W-1:0] ctrl_r;
    logic [`DPSM_BYTE_W-1:0] ctrl_nxt;
    logic [`DPSM_BYTE_W-1:0] rdata;
    logic [`DPSM_BYTE_W-1:0] stat;
    logic serial;
    logic pd;
    logic twos;
    logic diff;

    assign serial = ~mode_s;

    always_comb begin
        stat = '0;
        stat[`DPSM_STAT_SER_BIT] = serial;
        stat[`DPSM_STAT_PD_BIT] = pd;
        stat[`DPSM_STAT_TWOS_BIT] = twos;
        stat[`DPSM_STAT_DIFF_BIT] = diff;
        case (adr_r)
            `DPSM_REG_CTRL: rdata = ctrl_r;
            `DPSM_REG_STAT: rdata = stat;
            default: rdata = '0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        adr_nxt = adr_r;
        fall_nxt = fall_r;
        ctrl_nxt = ctrl_r;
        if (mode_s) begin
            // mode pin high holds defaults
            ctrl_nxt = `DPSM_CTRL_RST;
            st_nxt = DPSM_D_IDLE;
            cnt_nxt = '0;
            fall_nxt = 1'b0;
        end else if (pdcs_s) begin
            // select released ends any transfer
            st_nxt = DPSM_D_IDLE;
            cnt_nxt = '0;
            fall_nxt = 1'b0;
        end else begin
            case (st_r)
                DPSM_D_IDLE: begin
                    st_nxt = DPSM_D_INSTR;
                    cnt_nxt = '0;
                end
                DPSM_D_INSTR: begin
                    if (sclk_rise) begin
                        sh_nxt = {sh_r[`DPSM_BYTE_W-2:0], fmt_s};
                        cnt_nxt = cnt_r + 3'd1;
                        if (cnt_r == 3'd7) begin
                            rd_nxt = sh_r[`DPSM_BYTE_W-2];
                            adr_nxt = {sh_r[`DPSM_ADDR_W-2:0], fmt_s};
                            st_nxt = DPSM_D_DATA;
                            fall_nxt = 1'b0;
                        end
                    end
                end
                DPSM_D_DATA: begin
                    if (cnt_r == 3'd0 && !fall_r && rd_r) begin
                        sh_nxt = rdata;
                    end
                    if (sclk_fall) begin
                        fall_nxt = 1'b1;
                    end
                    if (sclk_rise) begin
                        sh_nxt = {sh_r[`DPSM_BYTE_W-2:0], fmt_s};
                        cnt_nxt = cnt_r + 3'd1;
                        if (cnt_r == 3'd7) begin
                            st_nxt = DPSM_D_WAIT;
                            if (!rd_r && adr_r == `DPSM_REG_CTRL) begin
                                ctrl_nxt = {sh_r[`DPSM_BYTE_W-2:0], fmt_s};
                            end
                        end
                    end
                end
                DPSM_D_WAIT: begin
                    st_nxt = DPSM_D_WAIT;
                end
                default: begin
                    st_nxt = DPSM_D_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= DPSM_D_IDLE;
            cnt_r <= '0;
            sh_r <= '0;
            rd_r <= 1'b0;
            adr_r <= '0;
            fall_r <= 1'b0;
            ctrl_r <= `DPSM_CTRL_RST;
        end else if (i_ce) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            rd_r <= rd_nxt;
            adr_r <= adr_nxt;
            fall_r <= fall_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // device drives the data line only in its read phase
    assign lnk.fmt_dev_oe = serial & ~pdcs_s & (st_r == DPSM_D_DATA)
                            & rd_r & fall_r;
    assign lnk.fmt_dev_o = sh_r[`DPSM_BYTE_W-1];

    // effective settings per mode
    assign pd = serial ? ctrl_r[`DPSM_CTRL_PD_BIT] : pdcs_s;
    assign twos = serial ? ctrl_r[`DPSM_CTRL_TWOS_BIT] : fmt_s;
    // low picks single-ended, high differential
    assign diff = serial ? ctrl_r[`DPSM_CTRL_DIFF_BIT]
                         : sclk_s;

    // data word capture and output codes
    logic [DATA_W-1:0] code;
    logic [DATA_W-1:0] true_r;
    logic [DATA_W-1:0] true_nxt;
    logic [DATA_W-1:0] comp_r;
    logic [DATA_W-1:0] comp_nxt;
    logic pd_r;
    logic twos_r;
    logic diff_r;
    logic ser_r;

    always_comb begin
        // bit DATA_W-1 is msb, bit 0 lsb
        code = lnk.data_word;
        if (twos) begin
            code[DATA_W-1] = ~lnk.data_word[DATA_W-1];
        end
        true_nxt = code;
        comp_nxt = ~code;
        if (pd) begin
            true_nxt = '0;
            comp_nxt = '0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            true_r <= '0;
            comp_r <= '0;
            pd_r <= 1'b0;
            twos_r <= 1'b0;
            diff_r <= 1'b0;
            ser_r <= 1'b0;
        end else if (i_ce) begin
            true_r <= true_nxt;
            comp_r <= comp_nxt;
            pd_r <= pd;
            twos_r <= twos;
            diff_r <= diff;
            ser_r <= serial;
        end
    end

    assign o_true_code = true_r;
    assign o_comp_code = comp_r;
    assign o_powered_down = pd_r;
    assign o_clk_diff = diff_r;
    assign o_twos_fmt = twos_r;
    assign o_serial_mode = ser_r;
endmodule : dpsm_device

//--- logic/dpsm_cfg.svh
// constants for the pin-strap / serial-port converter control
`ifndef DPSM_CFG_SVH
`define DPSM_CFG_SVH

`define DPSM_DATA_W 10
`define DPSM_ADDR_W 5
`define DPSM_BYTE_W 8
`define DPSM_XFER_BITS 16
`define DPSM_INSTR_BITS 8
`define DPSM_RD_BIT 15
`define DPSM_SCLK_HALF 8
`define DPSM_RST_PULSE 4

`define DPSM_REG_CTRL 5'h00
`define DPSM_REG_STAT 5'h01
`define DPSM_CTRL_RST 8'h00
`define DPSM_CTRL_PD_BIT 0
`define DPSM_CTRL_TWOS_BIT 1
`define DPSM_CTRL_DIFF_BIT 2
`define DPSM_STAT_SER_BIT 0
`define DPSM_STAT_PD_BIT 1
`define DPSM_STAT_TWOS_BIT 2
`define DPSM_STAT_DIFF_BIT 3

`endif

//--- logic/dpsm_pkg.sv
// types shared by both ends
package dpsm_pkg;
    typedef enum logic [1:0] {
        DPSM_D_IDLE  = 2'b00,
        DPSM_D_INSTR = 2'b01,
        DPSM_D_DATA  = 2'b10,
        DPSM_D_WAIT  = 2'b11
    } dpsm_dev_st_e;

    typedef enum logic [1:0] {
        DPSM_H_IDLE  = 2'b00,
        DPSM_H_SHIFT = 2'b01,
        DPSM_H_END   = 2'b10,
        DPSM_H_RST   = 2'b11
    } dpsm_host_st_e;
endpackage : dpsm_pkg

//--- logic/dpsm_if.sv
// pin-level link between host and converter control
`timescale 1ns/1ps
`include "dpsm_cfg.svh"
interface dpsm_if;
    logic mode_sel;
    logic powerdown_or_select;
    logic clk_type_or_serial_clock;
    logic fmt_host_o;
    logic fmt_host_oe;
    logic fmt_dev_o;
    logic fmt_dev_oe;
    logic fmt_line;
    logic [`DPSM_DATA_W-1:0] data_word;

    // shared format/data line resolved from the enables
    assign fmt_line = fmt_dev_oe ? fmt_dev_o :
                      (fmt_host_oe ? fmt_host_o : 1'b0);

    modport device (
        input mode_sel, powerdown_or_select, clk_type_or_serial_clock,
        input fmt_line, data_word,
        output fmt_dev_o, fmt_dev_oe
    );
    modport host (
        output mode_sel, powerdown_or_select, clk_type_or_serial_clock,
        output fmt_host_o, fmt_host_oe, data_word,
        input fmt_line
    );
endinterface : dpsm_if

//--- logic/dpsm_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dpsm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // pins in, synchronised out
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            q_r <= '0;
        end else if (i_ce) begin
            meta_r <= i_d;
            q_r <= meta_r;
        end
    end

    assign o_q = q_r;
endmodule : dpsm_sync

//--- logic/dpsm_host.sv
// host end: strap levels, serial port master, data word source
`timescale 1ns/1ps
`include "dpsm_cfg.svh"
module dpsm_host
    import dpsm_pkg::*;
#(
    parameter int DATA_W = `DPSM_DATA_W,
    parameter int SCLK_HALF = `DPSM_SCLK_HALF,
    parameter int RST_PULSE = `DPSM_RST_PULSE
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // pin link
    dpsm_if.host lnk,
    // mode and strap levels
    input wire logic i_pin_mode,
    input wire logic i_cfg_reset,
    input wire logic i_strap_pd,
    input wire logic i_strap_twos,
    input wire logic i_strap_diff,
    // data word
    input wire logic [DATA_W-1:0] i_data,
    // serial command port
    input wire logic i_start,
    input wire logic i_read,
    input wire logic [`DPSM_ADDR_W-1:0] i_addr,
    input wire logic [`DPSM_BYTE_W-1:0] i_wdata,
    output logic o_busy,
    output logic o_done,
    output logic [`DPSM_BYTE_W-1:0] o_rdata
);
    dpsm_host_st_e st_r;
    dpsm_host_st_e st_nxt;
    logic [7:0] div_r;
    logic [7:0] div_nxt;
    logic [3:0] bit_r;
    logic [3:0] bit_nxt;
    logic [`DPSM_XFER_BITS-1:0] sh_r;
    logic [`DPSM_XFER_BITS-1:0] sh_nxt;
    logic [`DPSM_BYTE_W-1:0] rd_r;
    logic [`DPSM_BYTE_W-1:0] rd_nxt;
    logic sclk_r;
    logic sclk_nxt;
    logic cs_n_r;
    logic cs_n_nxt;
    logic done_r;
    logic done_nxt;
    logic [DATA_W-1:0] data_r;
    logic tick;
    logic is_rd;
    logic rdf_r;
    logic rdf_nxt;
    logic fmt_s;

    // returned data line is a pin, resynchronised before use
    dpsm_sync #(
        .W(1)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_d(lnk.fmt_line),
        .o_q(fmt_s)
    );

    assign tick = (div_r == 8'(SCLK_HALF - 1));
    // read flag kept apart, the frame register shifts away its top bit
    assign is_rd = rdf_r;

    always_comb begin
        st_nxt = st_r;
        div_nxt = div_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        rd_nxt = rd_r;
        sclk_nxt = sclk_r;
        cs_n_nxt = cs_n_r;
        rdf_nxt = rdf_r;
        done_nxt = 1'b0;
        case (st_r)
            DPSM_H_IDLE: begin
                div_nxt = '0;
                sclk_nxt = 1'b0;
                cs_n_nxt = 1'b1;
                if (i_cfg_reset && !i_pin_mode) begin
                    st_nxt = DPSM_H_RST;
                end else if (i_start && !i_pin_mode) begin
                    sh_nxt = {i_read, 2'b00, i_addr, i_wdata};
                    rdf_nxt = i_read;
                    bit_nxt = '0;
                    cs_n_nxt = 1'b0;
                    st_nxt = DPSM_H_SHIFT;
                end
            end
            DPSM_H_SHIFT: begin
                div_nxt = tick ? '0 : div_r + 8'd1;
                if (tick) begin
                    sclk_nxt = ~sclk_r;
                    if (!sclk_r) begin
                        if (bit_r >= 4'd8 && is_rd) begin
                            rd_nxt = {rd_r[`DPSM_BYTE_W-2:0], fmt_s};
                        end
                    end else begin
                        sh_nxt = {sh_r[`DPSM_XFER_BITS-2:0], 1'b0};
                        bit_nxt = bit_r + 4'd1;
                        if (bit_r == 4'd15) begin
                            st_nxt = DPSM_H_END;
                        end
                    end
                end
            end
            DPSM_H_END: begin
                div_nxt = tick ? '0 : div_r + 8'd1;
                if (tick) begin
                    cs_n_nxt = 1'b1;
                    done_nxt = 1'b1;
                    st_nxt = DPSM_H_IDLE;
                end
            end
            DPSM_H_RST: begin
                div_nxt = div_r + 8'd1;
                if (div_r == 8'(RST_PULSE - 1)) begin
                    div_nxt = '0;
                    done_nxt = 1'b1;
                    st_nxt = DPSM_H_IDLE;
                end
            end
            default: begin
                st_nxt = DPSM_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= DPSM_H_IDLE;
            div_r <= '0;
            bit_r <= '0;
            sh_r <= '0;
            rd_r <= '0;
            rdf_r <= 1'b0;
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            done_r <= 1'b0;
            data_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            rd_r <= rd_nxt;
            rdf_r <= rdf_nxt;
            sclk_r <= sclk_nxt;
            cs_n_r <= cs_n_nxt;
            done_r <= done_nxt;
            data_r <= i_data;
        end
    end

    // mode pin level, with reset pulse
    assign lnk.mode_sel = i_pin_mode | (st_r == DPSM_H_RST);
    assign lnk.powerdown_or_select = i_pin_mode ? i_strap_pd : cs_n_r;
    assign lnk.clk_type_or_serial_clock = i_pin_mode ? i_strap_diff
                                                     : sclk_r;
    // host drives data line always in pin mode, and in serial mode only in its own phase
    assign lnk.fmt_host_oe = i_pin_mode |
        ((st_r == DPSM_H_SHIFT) & ~(is_rd & bit_r >= 4'd8));
    assign lnk.fmt_host_o = i_pin_mode ? i_strap_twos
                                       : sh_r[`DPSM_XFER_BITS-1];
    assign lnk.data_word = data_r;

    assign o_busy = (st_r != DPSM_H_IDLE);
    assign o_done = done_r;
    assign o_rdata = rd_r;
endmodule : dpsm_host

//--- verif/dpsm_monitor.sv
// assertions on the pin link and the converter outputs
`timescale 1ns/1ps
`include "dpsm_cfg.svh"
module dpsm_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // link signals
    input wire logic mode_sel,
    input wire logic powerdown_or_select,
    input wire logic clk_type_or_serial_clock,
    input wire logic fmt_host_oe,
    input wire logic fmt_dev_oe,
    input wire logic fmt_line,
    input wire logic [`DPSM_DATA_W-1:0] data_word,
    // converter outputs
    input wire logic [`DPSM_DATA_W-1:0] o_true_code,
    input wire logic [`DPSM_DATA_W-1:0] o_comp_code,
    input wire logic o_powered_down,
    input wire logic o_clk_diff,
    input wire logic o_serial_mode
);
    logic [2:0] warm_r;
    logic pin_bin;
    logic pin_twos;
    // settle counter after reset or a clock-enable freeze
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            warm_r <= 3'h0;
        end else if (!i_ce) begin
            warm_r <= 3'h0;
        end else if (warm_r != 3'h7) begin
            warm_r <= warm_r + 3'h1;
        end
    end
    assign pin_bin = mode_sel && !powerdown_or_select && !fmt_line;
    assign pin_twos = mode_sel && !powerdown_or_select && fmt_line;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst || warm_r != 3'h7);

    a_mode_follow: assert property (
        $stable(mode_sel) [*4] |=> o_serial_mode != $past(mode_sel))
        else $error("mode flag does not follow mode pin");
    a_pd_pin: assert property (
        (mode_sel && powerdown_or_select) [*4] |=>
        o_powered_down && o_true_code == '0 && o_comp_code == '0)
        else $error("power-down pin not obeyed");
    a_word_binary: assert property (
        pin_bin [*4] |=> o_true_code == $past(data_word))
        else $error("binary word not applied");
    a_word_twos: assert property (
        pin_twos [*4] |=> o_true_code == ($past(data_word) ^ 10'h200))
        else $error("twos word not applied");
    a_comp_mirror: assert property (
        !o_powered_down |-> o_comp_code == ~o_true_code)
        else $error("complement output not mirrored");
    a_clk_type: assert property (
        (mode_sel && $stable(clk_type_or_serial_clock)) [*4] |=>
        o_clk_diff == $past(clk_type_or_serial_clock))
        else $error("clock receiver choice wrong");
    a_no_contend: assert property (
        !(fmt_dev_oe && fmt_host_oe))
        else $error("both ends drive data line");
    a_dev_quiet: assert property (
        (mode_sel || powerdown_or_select) [*4] |=> !fmt_dev_oe)
        else $error("device drives line while deselected");
    a_sclk_idle: assert property (
        (!mode_sel && powerdown_or_select) [*4] |-> !clk_type_or_serial_clock)
        else $error("serial clock not idle low");

    c_pin_twos: cover property (pin_twos [*4]);
    c_dev_read: cover property (!powerdown_or_select && fmt_dev_oe);
    c_cfg_pulse: cover property (o_serial_mode && $rose(mode_sel));
endmodule : dpsm_monitor

//--- verif/dpsm_bench.sv
// self-checking bench: both ends joined by the pin link
`timescale 1ns/1ps
`include "dpsm_cfg.svh"
module dpsm_bench;
    import dpsm_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic ce = 1'b1;
    logic pin_mode = 1'b1;
    logic cfg_reset = 1'b0;
    logic start = 1'b0;
    logic read = 1'b0;
    logic s_pd = 1'b0;
    logic s_twos = 1'b0;
    logic s_diff = 1'b0;
    logic [9:0] data = 10'h000;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, v;
    logic busy, done, pd, diff, twos, ser;
    logic [9:0] t_code, c_code, e;
    int err_total = 0;
    int cmp_count = 0;

    dpsm_if dpsm_if_i ();
    dpsm_device dpsm_device_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
        .lnk(dpsm_if_i.device), .o_true_code(t_code), .o_comp_code(c_code),
        .o_powered_down(pd), .o_clk_diff(diff), .o_twos_fmt(twos),
        .o_serial_mode(ser));
    dpsm_host dpsm_host_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
        .lnk(dpsm_if_i.host), .i_pin_mode(pin_mode), .i_cfg_reset(cfg_reset),
        .i_strap_pd(s_pd), .i_strap_twos(s_twos), .i_strap_diff(s_diff),
        .i_data(data), .i_start(start), .i_read(read), .i_addr(addr),
        .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_rdata(rdata));
    dpsm_monitor dpsm_monitor_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
        .mode_sel(dpsm_if_i.mode_sel),
        .powerdown_or_select(dpsm_if_i.powerdown_or_select),
        .clk_type_or_serial_clock(dpsm_if_i.clk_type_or_serial_clock),
        .fmt_host_oe(dpsm_if_i.fmt_host_oe),
        .fmt_dev_oe(dpsm_if_i.fmt_dev_oe), .fmt_line(dpsm_if_i.fmt_line),
        .data_word(dpsm_if_i.data_word), .o_true_code(t_code),
        .o_comp_code(c_code), .o_powered_down(pd), .o_clk_diff(diff),
        .o_serial_mode(ser));

    always #20 i_clk = ~i_clk;

    function automatic logic [9:0] exp_code(logic [9:0] w, logic tw, p);
        return p ? 10'h000 : (tw ? w ^ 10'h200 : w);
    endfunction : exp_code

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    // one serial frame, or a config reset pulse when rs is set
    task automatic op(input logic rs, rd, input logic [4:0] a,
                      input logic [7:0] d);
        int n;
        read = rd;
        addr = a;
        wdata = d;
        cfg_reset = rs;
        start = !rs;
        tick(1);
        cfg_reset = 1'b0;
        start = 1'b0;
        chk("busy_on", 16'(busy), 16'h1);
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        chk("op_done", 16'(done), 16'h1);
        chk("busy_off", 16'(busy), 16'h0);
        tick(1);
    endtask : op

    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        conclude();
    end

    initial begin
        void'($urandom(32'hC2CAF175));
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        tick(6);
        // clock enable low freezes both ends
        data = 10'h155;
        tick(3);
        ce = 1'b0;
        data = 10'h2AA;
        tick(4);
        chk("ce_hold", 16'(t_code), 16'h0155);
        ce = 1'b1;
        tick(3);
        chk("ce_run", 16'(t_code), 16'h02AA);
        $display("test clock_enable done");
        // pin-strap mode, every strap combination
        for (int k = 0; k < 8; k++) begin
            {s_pd, s_twos, s_diff} = 3'(k);
            tick(6);
            for (int j = 0; j < 6; j++) begin
                data = (j == 0) ? 10'h000 : (j == 1) ? 10'h3FF : 10'($urandom);
                tick(3);
                e = exp_code(data, s_twos, s_pd);
                chk("true_code", 16'(t_code), 16'(e));
                e = s_pd ? 10'h000 : ~exp_code(data, s_twos, 1'b0);
                chk("comp_code", 16'(c_code), 16'(e));
            end
            chk("straps", 16'({pd, twos, diff}), 16'(k));
        end
        $display("test pin_strap done");
        // serial-port mode register traffic
        pin_mode = 1'b0;
        s_pd = 1'b0;
        tick(6);
        chk("serial_mode", 16'(ser), 16'h1);
        for (int k = 0; k < 5; k++) begin
            v = (k == 0) ? 8'h07 : 8'($urandom) & 8'h07;
            op(1'b0, 1'b0, 5'h00, v);
            op(1'b0, 1'b1, 5'h00, 8'h00);
            chk("ctrl", 16'(rdata), 16'(v));
            op(1'b0, 1'b1, 5'h01, 8'h00);
            chk("status", 16'(rdata), 16'({v[2:0], 1'b1}));
            data = 10'($urandom);
            tick(3);
            e = exp_code(data, v[1], v[0]);
            chk("serial_code", 16'(t_code), 16'(e));
        end
        op(1'b0, 1'b0, 5'h1F, 8'hFF);
        op(1'b0, 1'b1, 5'h1F, 8'h00);
        chk("unmapped", 16'(rdata), 16'h0);
        op(1'b0, 1'b0, 5'h00, 8'h07);
        op(1'b0, 1'b0, 5'h01, 8'h00);
        op(1'b0, 1'b1, 5'h01, 8'h00);
        chk("status_ro", 16'(rdata), 16'h000F);
        op(1'b1, 1'b0, 5'h00, 8'h00);
        tick(6);
        op(1'b0, 1'b1, 5'h00, 8'h00);
        chk("ctrl_reset", 16'(rdata), 16'h0);
        chk("pd_reset", 16'(pd), 16'h0);
        $display("test serial_port done");
        conclude();
    end
endmodule : dpsm_bench
